//--- rtl/guard_pkg.sv
// Constants, types and address helpers for the flash self-programming guard
package guard_pkg;

    // ----------------------------------------------------------------
    // Address map
    // ----------------------------------------------------------------
    localparam int ADDR_W = 16;
    localparam logic [ADDR_W-1:0] NC_BOUNDARY = 16'hC000;
    localparam logic [ADDR_W-1:0] LOADER_START_0 = 16'hF800;
    localparam logic [ADDR_W-1:0] LOADER_START_1 = 16'hF000;
    localparam logic [ADDR_W-1:0] LOADER_START_2 = 16'hE000;
    localparam logic [ADDR_W-1:0] LOADER_START_3 = 16'hC000;

    // ----------------------------------------------------------------
    // Lock bit positions and reset values (1 = unprogrammed)
    // ----------------------------------------------------------------
    localparam int LK_APP_LO = 0;
    localparam int LK_APP_HI = 1;
    localparam int LK_LDR_LO = 2;
    localparam int LK_LDR_HI = 3;
    localparam logic [3:0] LOCK_RESET = 4'hF;
    localparam logic [1:0] GEN_LOCK_RESET = 2'h3;

    // ----------------------------------------------------------------
    // Store operation kinds and guard states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        OP_ERASE = 2'h0,
        OP_WRITE = 2'h1,
        OP_BUF_LOAD = 2'h2,
        OP_LOCK_SET = 2'h3
    } op_kind_e;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_RUN = 3'h2,
        ST_HALT = 3'h4
    } guard_state_e;

    // ----------------------------------------------------------------
    // Region helpers
    // ----------------------------------------------------------------
    function automatic logic in_nonconcurrent(input logic [ADDR_W-1:0] a);
        in_nonconcurrent = (a >= NC_BOUNDARY);
    endfunction

    function automatic logic in_loader(input logic [ADDR_W-1:0] a,
                                       input logic [1:0] size);
        logic [ADDR_W-1:0] start;
        case (size)
            2'h0: start = LOADER_START_0;
            2'h1: start = LOADER_START_1;
            2'h2: start = LOADER_START_2;
            default: start = LOADER_START_3;
        endcase
        // Never let the loader reach below the fixed boundary
        if (start < NC_BOUNDARY) begin
            start = NC_BOUNDARY;
        end
        in_loader = (a >= start);
    endfunction

endpackage

//--- rtl/lock_if.sv
// Boot-lock fields shared between the lock store and its decoders
`timescale 1ns/1ps
interface lock_if;
    logic [3:0] fields;

    modport store (output fields);
    modport view (input fields);
endinterface

//--- rtl/lock_store.sv
// Boot-lock and general lock bit storage
`timescale 1ns/1ps
module lock_store
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic prog_en_i,
    input wire logic [3:0] prog_val_i,
    input wire logic ext_lock_wr_i,
    input wire logic [3:0] ext_lock_val_i,
    input wire logic ext_gen_wr_i,
    input wire logic [1:0] ext_gen_val_i,
    input wire logic chip_erase_i,
    output logic [1:0] general_lock_o,
    lock_if.store lk
);
    import guard_pkg::*;
    logic [3:0] lock_r;
    logic [3:0] lock_nxt;
    logic [1:0] gen_r;
    logic [1:0] gen_nxt;

    // Programming only clears bits; only chip erase sets them again
    always_comb begin
        lock_nxt = lock_r;
        gen_nxt = gen_r;
        if (prog_en_i) begin
            lock_nxt = lock_nxt & prog_val_i; // RULE9
        end
        if (ext_lock_wr_i) begin
            lock_nxt = lock_nxt & ext_lock_val_i; // RULE9
        end
        if (ext_gen_wr_i) begin
            gen_nxt = gen_nxt & ext_gen_val_i; // RULE9
        end
        if (chip_erase_i) begin
            lock_nxt = LOCK_RESET; // RULE9
            gen_nxt = GEN_LOCK_RESET;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            lock_r <= LOCK_RESET;
            gen_r <= GEN_LOCK_RESET;
        end else begin
            lock_r <= lock_nxt;
            gen_r <= gen_nxt;
        end
    end

    assign lk.fields = lock_r;
    assign general_lock_o = gen_r;

    lock_only_clears_a: assert property (@(posedge clk_i) // RULE9
        disable iff (!reset_n_i)
        ((lock_r & ~$past(lock_r)) != 4'h0) |-> $past(chip_erase_i))
        else $error("lock bit unprogrammed without chip erase");
endmodule

//--- rtl/lock_decode.sv
// Region classification and lock permission decode for one access
`timescale 1ns/1ps
module lock_decode
(
    input wire logic [guard_pkg::ADDR_W-1:0] exec_addr_i,
    input wire logic [guard_pkg::ADDR_W-1:0] target_addr_i,
    input wire logic [1:0] loader_size_i,
    output logic target_nc_o,
    output logic target_loader_o,
    output logic exec_loader_o,
    output logic write_ok_o,
    output logic read_ok_o,
    lock_if.view lk
);
    import guard_pkg::*;
    // A zero bit is programmed; low bit guards writes, high bit reads
    always_comb begin
        target_nc_o = in_nonconcurrent(target_addr_i); // RULE23
        target_loader_o = in_loader(target_addr_i, loader_size_i); // RULE6
        exec_loader_o = in_loader(exec_addr_i, loader_size_i);
        if (target_loader_o) begin
            write_ok_o = lk.fields[LK_LDR_LO]; // RULE16 RULE17 RULE20
            read_ok_o = exec_loader_o || lk.fields[LK_LDR_HI]; // RULE18 RULE19
        end else begin
            write_ok_o = lk.fields[LK_APP_LO]; // RULE12 RULE13 RULE20
            read_ok_o = !exec_loader_o || lk.fields[LK_APP_HI]; // RULE14 RULE15
        end
    end
endmodule

//--- rtl/flash_rww_boot_lock_guard.sv
// Self-programming guard: stall, busy flag, boot-lock and interrupt gating
//
// Summary of operation
// RULE1: Stall decision follows programmed page address.
// RULE2: Concurrent-region page op keeps core running.
// RULE3: Non-concurrent page op halts the core.
// RULE4: Concurrent region unreadable during any operation.
// RULE5: Software avoids concurrent region while programming.
// RULE6: Loader region lies inside non-concurrent region.
// RULE7: Busy flag reads one while region blocked.
// RULE8: Busy flag stays until software clears it.
// RULE9: Locks program anytime, unprogram by erase only. Lock-set stores act only when idle, from loader code.
// RULE10: General write lock ignores program stores.
// RULE11: General read/write lock ignores loads, stores.
// RULE12: Application lock 11: no restriction.
// RULE13: Application lock 10: stores to application suppressed.
// RULE14: Application lock 00: stores, loader reads blocked.
// RULE15: Application lock 01: loader reads of application blocked.
// RULE16: Loader lock 11: no restriction.
// RULE17: Loader lock 10: stores to loader suppressed.
// RULE18: Loader lock 00: stores, application reads blocked.
// RULE19: Loader lock 01: application reads of loader blocked.
// RULE20: Lock bit one unprogrammed, zero programmed.
// RULE21: Stores start operations only from loader code.
// RULE22: Forbidden accesses change nothing, start nothing.
// RULE23: Region boundary is a fixed constant.
`timescale 1ns/1ps
module flash_rww_boot_lock_guard
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [guard_pkg::ADDR_W-1:0] exec_addr_i,
    input wire logic store_req_i,
    input wire guard_pkg::op_kind_e store_kind_i,
    input wire logic [guard_pkg::ADDR_W-1:0] store_addr_i,
    input wire logic [3:0] store_lock_val_i,
    input wire logic load_req_i,
    input wire logic [guard_pkg::ADDR_W-1:0] load_addr_i,
    input wire logic fetch_req_i,
    input wire logic [guard_pkg::ADDR_W-1:0] fetch_addr_i,
    input wire logic busy_clear_i,
    input wire logic flash_done_i,
    input wire logic vectors_in_loader_i,
    input wire logic [1:0] loader_size_setting_i,
    input wire logic ext_lock_wr_i,
    input wire logic [3:0] ext_lock_val_i,
    input wire logic ext_gen_wr_i,
    input wire logic [1:0] ext_gen_val_i,
    input wire logic chip_erase_i,
    output logic core_halt_o,
    output logic concurrent_region_busy_o,
    output logic flash_start_o,
    output guard_pkg::op_kind_e flash_kind_o,
    output logic [guard_pkg::ADDR_W-1:0] flash_page_o,
    output logic buf_load_o,
    output logic store_refused_o,
    output logic load_grant_o,
    output logic fetch_grant_o,
    output logic irq_allow_o,
    output logic [3:0] lock_fields_o,
    output logic [1:0] general_lock_o
);
    import guard_pkg::*;

    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);

    // ----------------------------------------------------------------
    // Lock storage and decode
    // ----------------------------------------------------------------
    lock_if lk ();

    logic st_nc;
    logic st_loader;
    logic exec_loader;
    logic st_write_ok;
    logic ld_nc;
    logic ld_read_ok;
    logic lock_prog;

    lock_store u_store (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .prog_en_i(lock_prog),
        .prog_val_i(store_lock_val_i),
        .ext_lock_wr_i(ext_lock_wr_i),
        .ext_lock_val_i(ext_lock_val_i),
        .ext_gen_wr_i(ext_gen_wr_i),
        .ext_gen_val_i(ext_gen_val_i),
        .chip_erase_i(chip_erase_i),
        .general_lock_o(general_lock_o),
        .lk(lk.store)
    );

    lock_decode u_store_dec (
        .exec_addr_i(exec_addr_i),
        .target_addr_i(store_addr_i),
        .loader_size_i(loader_size_setting_i),
        .target_nc_o(st_nc),
        .target_loader_o(st_loader),
        .exec_loader_o(exec_loader),
        .write_ok_o(st_write_ok),
        .read_ok_o(),
        .lk(lk.view)
    );

    lock_decode u_load_dec (
        .exec_addr_i(exec_addr_i),
        .target_addr_i(load_addr_i),
        .loader_size_i(loader_size_setting_i),
        .target_nc_o(ld_nc),
        .target_loader_o(),
        .exec_loader_o(),
        .write_ok_o(),
        .read_ok_o(ld_read_ok),
        .lk(lk.view)
    );

    assign lock_fields_o = lk.fields;

    // ----------------------------------------------------------------
    // Store acceptance
    // ----------------------------------------------------------------
    guard_state_e state_r;
    guard_state_e state_nxt;
    logic busy_r;
    logic busy_nxt;
    logic start_r;
    logic start_nxt;
    logic buf_r;
    logic buf_nxt;
    logic refused_r;
    logic refused_nxt;
    op_kind_e kind_r;
    op_kind_e kind_nxt;
    logic [ADDR_W-1:0] page_r;
    logic [ADDR_W-1:0] page_nxt;
    logic idle;
    logic page_op;
    logic start_ok;

    assign idle = (state_r == ST_IDLE);
    assign page_op = (store_kind_i == OP_ERASE) || (store_kind_i == OP_WRITE);
    // General lock bits take no part in this decision
    assign start_ok = store_req_i && idle && exec_loader // RULE21 RULE10
                      && page_op && st_write_ok; // RULE22 RULE11
    assign lock_prog = store_req_i && idle && exec_loader // RULE21
                       && (store_kind_i == OP_LOCK_SET); // RULE9

    // ----------------------------------------------------------------
    // Operation state and busy flag
    // ----------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        busy_nxt = busy_r;
        start_nxt = 1'b0;
        buf_nxt = 1'b0;
        refused_nxt = 1'b0;
        kind_nxt = kind_r;
        page_nxt = page_r;
        unique case (state_r)
            ST_IDLE: begin
                if (busy_clear_i) begin
                    busy_nxt = 1'b0; // RULE8
                end
                if (start_ok) begin
                    // Stall choice from the page under program
                    state_nxt = st_nc ? ST_HALT : ST_RUN; // RULE1 RULE2 RULE3
                    busy_nxt = 1'b1; // RULE4 RULE7
                    start_nxt = 1'b1;
                    kind_nxt = store_kind_i;
                    page_nxt = store_addr_i;
                end else if (store_req_i && store_kind_i == OP_BUF_LOAD
                             && exec_loader) begin
                    buf_nxt = 1'b1;
                end else if (store_req_i && !lock_prog) begin
                    refused_nxt = 1'b1; // RULE22
                end
            end
            ST_RUN, ST_HALT: begin
                // Clear attempts during an operation are ignored
                if (store_req_i) begin
                    refused_nxt = 1'b1;
                end
                if (flash_done_i) begin
                    state_nxt = ST_IDLE; // RULE8
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_r <= ST_IDLE;
            busy_r <= 1'b0;
            start_r <= 1'b0;
            buf_r <= 1'b0;
            refused_r <= 1'b0;
            kind_r <= OP_ERASE;
            page_r <= '0;
        end else begin
            state_r <= state_nxt;
            busy_r <= busy_nxt;
            start_r <= start_nxt;
            buf_r <= buf_nxt;
            refused_r <= refused_nxt;
            kind_r <= kind_nxt;
            page_r <= page_nxt;
        end
    end

    assign core_halt_o = (state_r == ST_HALT); // RULE3
    assign concurrent_region_busy_o = busy_r; // RULE7
    assign flash_start_o = start_r;
    assign flash_kind_o = kind_r;
    assign flash_page_o = page_r;
    assign buf_load_o = buf_r;
    assign store_refused_o = refused_r;

    // ----------------------------------------------------------------
    // Read gating and interrupt gating
    // ----------------------------------------------------------------
    // Code does not rely on software staying out while busy; concurrent reads are refused
    assign fetch_grant_o = fetch_req_i && !core_halt_o // RULE3
        && !(busy_r && !in_nonconcurrent(fetch_addr_i)); // RULE4 RULE5
    assign load_grant_o = load_req_i && !core_halt_o && ld_read_ok // RULE22
        && !(busy_r && !ld_nc); // RULE4 RULE8
    assign irq_allow_o = !((!lk.fields[LK_APP_HI] && vectors_in_loader_i
                            && !exec_loader) // RULE14 RULE15
                           || (!lk.fields[LK_LDR_HI] && !vectors_in_loader_i
                               && exec_loader)); // RULE18 RULE19

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence nc_start_s;
        start_ok && st_nc;
    endsequence

    sequence conc_start_s;
        start_ok && !st_nc;
    endsequence

    halt_on_nc_a: assert property ( // RULE3
        nc_start_s |=> core_halt_o && flash_start_o)
        else $error("no halt for non-concurrent page op");

    run_on_conc_a: assert property ( // RULE2
        conc_start_s |=> !core_halt_o && flash_start_o)
        else $error("core halted for concurrent page op");

    halt_hold_a: assert property ( // RULE1
        core_halt_o && !flash_done_i
        |=> core_halt_o && flash_page_o == $past(flash_page_o))
        else $error("halt dropped before op done");

    busy_set_a: assert property ( // RULE7
        start_ok |=> concurrent_region_busy_o [*2] )
        else $error("busy flag not set by op start");

    busy_sticky_a: assert property ( // RULE8
        busy_r && !(busy_clear_i && idle) |=> busy_r)
        else $error("busy flag dropped without clear");

    conc_block_a: assert property ( // RULE4
        busy_r && fetch_req_i && !in_nonconcurrent(fetch_addr_i)
        |-> !fetch_grant_o)
        else $error("concurrent fetch granted while busy");

    app_origin_a: assert property ( // RULE21
        store_req_i && !exec_loader |=> !flash_start_o && !buf_load_o)
        else $error("store from application started op");

    write_lock_a: assert property ( // RULE13
        store_req_i && !st_loader && !lk.fields[LK_APP_LO] |=> !flash_start_o)
        else $error("store to locked application started op");

    ldr_write_lock_a: assert property ( // RULE17
        store_req_i && st_loader && !lk.fields[LK_LDR_LO] |=> !flash_start_o)
        else $error("store to locked loader started op");

    read_lock_a: assert property ( // RULE19
        load_req_i && !exec_loader && !lk.fields[LK_LDR_HI]
        && in_loader(load_addr_i, loader_size_setting_i) |-> !load_grant_o)
        else $error("application read of locked loader granted");

    irq_gate_a: assert property ( // RULE15
        !lk.fields[LK_APP_HI] && vectors_in_loader_i && !exec_loader
        |-> !irq_allow_o)
        else $error("interrupt allowed in locked application");

    loader_nc_a: assert property ( // RULE6
        st_loader |-> st_nc)
        else $error("loader address outside non-concurrent region");

    app_refuse_a: assert property ( // RULE21
        store_req_i && idle && !exec_loader |=> store_refused_o)
        else $error("store from application not refused");

endmodule

//--- test/core_model.sv
// Partner model: core issuing program stores, plus flash completion
`timescale 1ns/1ps
module core_model
(
    input wire logic clk_i,
    input wire logic flash_start_i,
    output logic [guard_pkg::ADDR_W-1:0] exec_addr_o,
    output logic store_req_o,
    output guard_pkg::op_kind_e store_kind_o,
    output logic [guard_pkg::ADDR_W-1:0] store_addr_o,
    output logic [3:0] store_lock_val_o,
    output logic flash_done_o
);
    import guard_pkg::*;
    // Array answer delay in cycles; the bench may slow it down
    int done_wait = 3;

    initial begin
        exec_addr_o = 16'hF800;
        store_req_o = 1'b0;
        store_kind_o = OP_ERASE;
        store_addr_o = 16'h0000;
        store_lock_val_o = 4'hF;
        flash_done_o = 1'b0;
    end

    // Released address and lock value are inverted so a stale value never looks live
    task automatic issue(input op_kind_e kind, input logic [15:0] addr,
            input logic [15:0] exec, input logic [3:0] val);
        @(posedge clk_i);
        #1;
        exec_addr_o = exec;
        store_req_o = 1'b1;
        store_kind_o = kind;
        store_addr_o = addr;
        store_lock_val_o = val;
        @(posedge clk_i);
        #1;
        store_req_o = 1'b0;
        store_addr_o = ~addr;
        store_lock_val_o = ~val;
    endtask

    // Code jumps between regions only between programming steps
    task automatic set_exec(input logic [15:0] exec);
        @(posedge clk_i);
        #1;
        exec_addr_o = exec;
    endtask

    // One completion pulse for every started operation
    always @(posedge clk_i) begin
        #1;
        if (flash_start_i === 1'b1) begin
            repeat (done_wait) @(posedge clk_i);
            #1;
            flash_done_o = 1'b1;
            @(posedge clk_i);
            #1;
            flash_done_o = 1'b0;
        end
    end
endmodule

//--- test/flash_rww_boot_lock_guard_tb.sv
// Self-checking bench for the flash self-programming guard
`timescale 1ns/1ps
module flash_rww_boot_lock_guard_tb;
    import guard_pkg::*;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic fetch_req = 1'b0;
    logic [15:0] fetch_addr = 16'h0000;
    logic load_req = 1'b0;
    logic [15:0] load_addr = 16'h0000;
    logic busy_clear = 1'b0;
    logic vectors = 1'b0;
    logic [1:0] loader_size = 2'h0;
    logic ext_lock_wr = 1'b0;
    logic [3:0] ext_lock_val = 4'hF;
    logic ext_gen_wr = 1'b0;
    logic [1:0] ext_gen_val = 2'h3;
    logic chip_erase = 1'b0;
    logic [15:0] exec_addr, store_addr, flash_page;
    logic store_req, flash_done, core_halt, busy, flash_start, buf_load;
    logic refused, load_grant, fetch_grant, irq_allow;
    op_kind_e store_kind, flash_kind;
    logic [3:0] lock_val, lock_fields;
    logic [1:0] general_lock;
    int failures = 0;
    int samples_checked = 0;
    int cycles = 0;

    initial begin
        forever #2 clk_i = ~clk_i;
    end

    core_model i_core (.clk_i(clk_i), .flash_start_i(flash_start),
        .exec_addr_o(exec_addr), .store_req_o(store_req),
        .store_kind_o(store_kind), .store_addr_o(store_addr),
        .store_lock_val_o(lock_val), .flash_done_o(flash_done));

    flash_rww_boot_lock_guard i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .exec_addr_i(exec_addr), .store_req_i(store_req),
        .store_kind_i(store_kind), .store_addr_i(store_addr),
        .store_lock_val_i(lock_val), .load_req_i(load_req),
        .load_addr_i(load_addr), .fetch_req_i(fetch_req),
        .fetch_addr_i(fetch_addr), .busy_clear_i(busy_clear),
        .flash_done_i(flash_done), .vectors_in_loader_i(vectors),
        .loader_size_setting_i(loader_size), .ext_lock_wr_i(ext_lock_wr),
        .ext_lock_val_i(ext_lock_val), .ext_gen_wr_i(ext_gen_wr),
        .ext_gen_val_i(ext_gen_val), .chip_erase_i(chip_erase),
        .core_halt_o(core_halt), .concurrent_region_busy_o(busy),
        .flash_start_o(flash_start), .flash_kind_o(flash_kind),
        .flash_page_o(flash_page), .buf_load_o(buf_load),
        .store_refused_o(refused), .load_grant_o(load_grant),
        .fetch_grant_o(fetch_grant), .irq_allow_o(irq_allow),
        .lock_fields_o(lock_fields), .general_lock_o(general_lock));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic finish_test();
        if (failures == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_vec(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tick();
        @(posedge clk_i);
        #1;
    endtask

    // Waits for completion, then software clears the flag
    task automatic wait_done();
        int n;
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (flash_done !== 1'b1 && n < 100);
        check_bit(n < 100, 1'b1);
        tick();
        check_bit(core_halt, 1'b0);
        check_bit(busy, 1'b1);
        fetch_addr = 16'h0100;
        load_addr = 16'hF900;
        busy_clear = 1'b1;
        #1;
        check_bit(fetch_grant, 1'b0);
        check_bit(load_grant, 1'b1);
        tick();
        busy_clear = 1'b0;
        check_bit(busy, 1'b0);
        check_bit(fetch_grant, 1'b1);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic op_case(input op_kind_e kind, input logic [15:0] page,
            input logic [15:0] exec, input logic [1:0] size, input logic h);
        loader_size = size;
        i_core.issue(kind, page, exec, 4'hF);
        check_bit(flash_start, 1'b1);
        check_vec(flash_page, page);
        check_vec(16'(flash_kind), 16'(kind));
        check_bit(core_halt, h);
        check_bit(busy, 1'b1);
        fetch_addr = exec;
        load_addr = page;
        #1;
        check_bit(fetch_grant, !h);
        check_bit(load_grant, 1'b0);
        wait_done();
    endtask

    task automatic refuse_case();
        i_core.issue(OP_WRITE, 16'h2000, 16'h1000, 4'hF);
        check_bit(refused, 1'b1);
        check_bit(flash_start, 1'b0);
        check_bit(busy, 1'b0);
        i_core.issue(OP_LOCK_SET, 16'h0000, 16'h1000, 4'h0);
        check_bit(refused, 1'b1);
        check_vec(16'(lock_fields), 16'h000F);
        i_core.issue(OP_BUF_LOAD, 16'h2000, 16'hF800, 4'hF);
        check_bit(buf_load, 1'b1);
        check_bit(flash_start, 1'b0);
        i_core.issue(OP_ERASE, 16'h2000, 16'hF800, 4'hF);
        i_core.issue(OP_WRITE, 16'h3000, 16'hF800, 4'hF);
        check_bit(refused, 1'b1);
        check_vec(flash_page, 16'h2000);
        wait_done();
    endtask

    // Sets one lock field to mode m, then probes store, load and irq
    task automatic mode_case(input logic ldr, input logic [1:0] m);
        logic [15:0] page;
        page = ldr ? 16'hF800 : 16'h1000;
        loader_size = 2'h0;
        chip_erase = 1'b1;
        tick();
        chip_erase = 1'b0;
        check_vec(16'(lock_fields), 16'h000F);
        if (ldr) begin
            ext_lock_val = {m, 2'b11};
            ext_lock_wr = 1'b1;
            tick();
            ext_lock_wr = 1'b0;
        end else begin
            i_core.issue(OP_LOCK_SET, 16'h0000, 16'hF800, {2'b11, m});
        end
        tick();
        check_vec(16'(lock_fields), ldr ? {m, 2'b11} : {2'b11, m});
        i_core.issue(OP_WRITE, page, 16'hF800, 4'hF);
        check_bit(flash_start, m[0]);
        check_bit(refused, !m[0]);
        if (m[0]) begin
            wait_done();
        end
        i_core.set_exec(ldr ? 16'h1000 : 16'hF800);
        load_addr = page | 16'h0100;
        vectors = !ldr;
        #1;
        check_bit(load_grant, m[1]);
        i_core.set_exec(page);
        #1;
        check_bit(irq_allow, m[1]);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            finish_test();
        end
    end

    initial begin
        repeat (16) @(posedge clk_i);
        #1;
        reset_n_i = 1'b1;
        check_vec(16'(lock_fields), 16'h000F);
        check_vec(16'(general_lock), 16'h0003);
        check_bit(core_halt, 1'b0);
        check_bit(busy, 1'b0);
        check_bit(irq_allow, 1'b1);
        fetch_req = 1'b1;
        load_req = 1'b1;
        ext_gen_val = 2'h0;
        ext_gen_wr = 1'b1;
        tick();
        ext_gen_wr = 1'b0;
        tick();
        check_vec(16'(general_lock), 16'h0000);
        op_case(OP_ERASE, 16'hD000, 16'hF800, 2'h0, 1'b1);
        i_core.done_wait = 40;
        op_case(OP_WRITE, 16'h2000, 16'hF800, 2'h0, 1'b0);
        i_core.done_wait = 3;
        op_case(OP_WRITE, 16'hBF80, 16'hC000, 2'h3, 1'b0);
        op_case(OP_ERASE, 16'hC000, 16'hF800, 2'h0, 1'b1);
        refuse_case();
        for (int i = 0; i < 4; i++) begin
            mode_case(1'b0, 2'(i));
        end
        for (int i = 0; i < 4; i++) begin
            mode_case(1'b1, 2'(i));
        end
        // Grants must follow the request lines, not only the address
        tick();
        fetch_req = 1'b0;
        load_req = 1'b0;
        #1;
        check_bit(fetch_grant, 1'b0);
        check_bit(load_grant, 1'b0);
        finish_test();
    end
endmodule
